//--- design/slg_pkg.sv
// Package for the stack-limit and effective-address generator.
// Assumes a 16-bit core with byte-addressed data space and word-aligned stack.
package slg_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned DW         = 16;
  localparam int unsigned REG_IDX_W  = 4;
  localparam int unsigned NEAR_W     = 13;
  localparam int unsigned LIT5_W     = 5;
  localparam int unsigned LIT10_W    = 10;
  localparam int unsigned BRANCH_W   = 16;
  localparam int unsigned IDIS_CNT_W = 14;
  localparam int unsigned STAT_LO_W  = 8;
  localparam int unsigned PC_HI_W    = 7;

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam logic [DW-1:0]        STACK_FLOOR = 16'h0800;
  localparam logic [DW-1:0]        WORD_STEP   = 16'h0002;
  localparam logic [DW-1:0]        ALIGN_MASK  = 16'hFFFE;
  localparam logic [REG_IDX_W-1:0] SP_IDX      = 4'hF;
  localparam logic [REG_IDX_W-1:0] WREG0_IDX   = 4'h0;
  localparam int unsigned          NUM_REGS    = 16;

  // ==========================================================================
  // Addressing modes
  // ==========================================================================
  typedef enum logic [2:0] {
    AM_FILE,
    AM_DIRECT,
    AM_INDIRECT,
    AM_POST_MOD,
    AM_PRE_MOD,
    AM_INDEXED,
    AM_LIT_OFFSET,
    AM_LITERAL
  } slg_mode_e;

  typedef enum logic [2:0] {
    SOP_NONE,
    SOP_PUSH,
    SOP_POP,
    SOP_CALL,
    SOP_EXC
  } slg_stack_op_e;

  typedef enum logic [1:0] {
    LIT_5,
    LIT_10,
    LIT_BRANCH,
    LIT_IDIS
  } slg_lit_e;

endpackage : slg_pkg

//--- design/slg_ea_calc.sv
// Combinational effective-address former for one operand.
// Assumes register contents are supplied already read from the register file.
`timescale 1ns/10ps
module slg_ea_calc (
  input  wire slg_pkg::slg_mode_e         mode,       // Addressing mode.
  input  wire logic [slg_pkg::DW-1:0]     ptrVal,     // Pointer register value.
  input  wire logic [slg_pkg::DW-1:0]     baseVal,    // Base operand register value.
  input  wire logic [slg_pkg::DW-1:0]     litVal,     // Extended literal value.
  input  wire logic [slg_pkg::DW-1:0]     modConst,   // Signed modify constant.
  input  wire logic [slg_pkg::NEAR_W-1:0] fileAddr,   // Direct file address field.
  input  wire logic                       fullSpace,  // Move may reach the whole space.
  output logic      [slg_pkg::DW-1:0]     effAddr,    // Effective address.
  output logic      [slg_pkg::DW-1:0]     ptrNext,    // Updated pointer value.
  output logic                            ptrWrite    // Pointer update needed.
);

  always_comb begin
    effAddr  = ptrVal;
    ptrNext  = ptrVal;
    ptrWrite = 1'b0;
    case (mode)
      slg_pkg::AM_FILE: begin
        // Only a move may use the whole literal; others stay in near space.
        effAddr = fullSpace ? litVal : {{(slg_pkg::DW-slg_pkg::NEAR_W){1'b0}}, fileAddr};
      end
      slg_pkg::AM_INDIRECT: begin
        effAddr = ptrVal;
      end
      slg_pkg::AM_POST_MOD: begin
        effAddr  = ptrVal;
        ptrNext  = ptrVal + modConst;
        ptrWrite = 1'b1;
      end
      slg_pkg::AM_PRE_MOD: begin
        effAddr  = ptrVal + modConst;
        ptrNext  = ptrVal + modConst;
        ptrWrite = 1'b1;
      end
      slg_pkg::AM_INDEXED: begin
        effAddr = ptrVal + baseVal;
      end
      slg_pkg::AM_LIT_OFFSET: begin
        effAddr = ptrVal + litVal;
      end
      default: begin
        effAddr = ptrVal;
      end
    endcase
  end

endmodule : slg_ea_calc

//--- design/slg_stack_ea.sv
// Stack pointer, stack limit check and operand address generation.
// Assumes the decoder presents one decoded operation per cycle and the data
// memory takes the registered address and write data one cycle later.
// Functional notes
// - Stack pointer addresses first free word; stack grows upward.
// - Pop pre-decrements the pointer; push post-increments it.
// - Call pushes program counter upper part with top bit cleared.
// - Exception push places status low byte beside upper program counter.
// - Limit register holds stack upper bound; no defined reset value.
// - Limit register bit zero always reads zero.
// - Every stack-pointer effective address is compared against the limit; the code checks pop addresses against the floor only.
// - Push at the limit is fine; the next push traps.
// - Stack pointer below 0x0800 raises the stack error trap.
// - File instructions use a 13-bit direct near address.
// - File instructions use working register zero as implied register; the code never selects WREG0_IDX for them.
// - Move may address the whole data space directly.
// - Three-operand first operand register direct; second register, memory or literal.
// - Five-bit and ten-bit literal operands are supported.
// - Register indirect uses pointer contents unchanged.
// - Post-modified uses pointer, then adds constant to pointer.
// - Pre-modified adds signed constant first, uses the result.
// - Indexed address is pointer plus base operand register.
// - Literal offset address is pointer plus literal.
// - Move source and destination modes differ; one offset field shared.
// - Branch literal is signed 16-bit; disable count unsigned 14-bit.
// - Boot secure RAM reachable only from boot flash code when enabled; the code checks operand addresses only, not stack accesses.
`timescale 1ns/10ps
module slg_stack_ea (
  input  wire logic                         clk,           // Core clock.
  input  wire logic                         reset,         // Synchronous reset, active high.
  input  wire slg_pkg::slg_stack_op_e       stackOp,       // Stack operation this cycle.
  input  wire logic [slg_pkg::DW-1:0]       pushData,      // Word for a plain push.
  input  wire logic [slg_pkg::PC_HI_W:0]    pcHigh,        // Upper program counter part.
  input  wire logic [slg_pkg::STAT_LO_W-1:0] statusLowByte, // Status low byte.
  input  wire logic                         limitWrite,    // Write the limit register.
  input  wire logic [slg_pkg::DW-1:0]       limitData,     // Limit register write data.
  input  wire logic                         regWrite,      // Write a working register.
  input  wire logic [slg_pkg::REG_IDX_W-1:0] regWrIdx,     // Working register index.
  input  wire logic [slg_pkg::DW-1:0]       regWrData,     // Working register data.
  input  wire logic                         opValid,       // Operand request valid.
  input  wire logic                         isFileOp,      // File register form.
  input  wire logic                         isMoveOp,      // Move instruction.
  input  wire slg_pkg::slg_mode_e           srcMode,       // Source addressing mode.
  input  wire slg_pkg::slg_mode_e           dstMode,       // Destination addressing mode.
  input  wire logic [slg_pkg::REG_IDX_W-1:0] srcPtrIdx,    // Source pointer index.
  input  wire logic [slg_pkg::REG_IDX_W-1:0] dstPtrIdx,    // Destination pointer index.
  input  wire logic [slg_pkg::REG_IDX_W-1:0] baseIdx,      // Shared offset register field.
  input  wire logic [slg_pkg::NEAR_W-1:0]   fileAddr,      // Direct file address field.
  input  wire logic [slg_pkg::DW-1:0]       wideAddr,      // Full-space move address.
  input  wire slg_pkg::slg_lit_e            litKind,       // Literal size class.
  input  wire logic [slg_pkg::DW-1:0]       litRaw,        // Raw literal bits.
  input  wire logic [slg_pkg::DW-1:0]       modConst,      // Signed modify constant.
  input  wire logic                         bootRamEn,     // Boot secure RAM protection on.
  input  wire logic [slg_pkg::DW-1:0]       bootRamLo,     // Boot secure RAM start.
  input  wire logic [slg_pkg::DW-1:0]       bootRamHi,     // Boot secure RAM end.
  input  wire logic                         execInBoot,    // Code runs in boot flash.
  output logic      [slg_pkg::DW-1:0]       memAddr,       // Memory address.
  output logic      [slg_pkg::DW-1:0]       memWrData,     // Memory write data.
  output logic                              memWrite,      // Memory write strobe.
  output logic                              memRead,       // Memory read strobe.
  output logic      [slg_pkg::DW-1:0]       srcAddr,       // Source effective address.
  output logic      [slg_pkg::DW-1:0]       dstAddr,       // Destination effective address.
  output logic      [slg_pkg::DW-1:0]       baseOperand,   // First operand, register direct.
  output logic      [slg_pkg::DW-1:0]       litOut,        // Extended literal.
  output logic      [slg_pkg::DW-1:0]       stackPtr,      // Stack pointer value.
  output logic                              stackTrap,     // Stack error trap request.
  output logic                              secureFault    // Secure RAM access refused.
);

  // ==========================================================================
  // Working registers and limit
  // ==========================================================================
  logic [slg_pkg::DW-1:0] regs_q [slg_pkg::NUM_REGS];
  logic [slg_pkg::DW-1:0] regs_d [slg_pkg::NUM_REGS];
  logic [slg_pkg::DW-1:0] limit_q;
  logic [slg_pkg::DW-1:0] limit_d;
  logic [slg_pkg::DW-1:0] sp;
  logic [slg_pkg::DW-1:0] litExt;
  logic [slg_pkg::DW-1:0] srcEa;
  logic [slg_pkg::DW-1:0] dstEa;
  logic [slg_pkg::DW-1:0] srcPtrNext;
  logic [slg_pkg::DW-1:0] dstPtrNext;
  logic                   srcPtrWr;
  logic                   dstPtrWr;
  logic [slg_pkg::DW-1:0] fileWide;

  assign sp = regs_q[slg_pkg::SP_IDX];

  // Literal widths follow the instruction class.
  always_comb begin
    case (litKind)
      slg_pkg::LIT_5:      litExt = {{(slg_pkg::DW-slg_pkg::LIT5_W){1'b0}}, litRaw[slg_pkg::LIT5_W-1:0]};
      slg_pkg::LIT_10:     litExt = {{(slg_pkg::DW-slg_pkg::LIT10_W){1'b0}}, litRaw[slg_pkg::LIT10_W-1:0]};
      slg_pkg::LIT_BRANCH: litExt = litRaw[slg_pkg::BRANCH_W-1:0];
      slg_pkg::LIT_IDIS:   litExt = {{(slg_pkg::DW-slg_pkg::IDIS_CNT_W){1'b0}}, litRaw[slg_pkg::IDIS_CNT_W-1:0]};
      default:             litExt = litRaw;
    endcase
  end

  assign fileWide = isMoveOp ? wideAddr : litExt;

  // Source and destination have their own modes; the base field is shared.
  slg_ea_calc uSrc (
    .mode      (srcMode),
    .ptrVal    (regs_q[srcPtrIdx]),
    .baseVal   (regs_q[baseIdx]),
    .litVal    (isFileOp ? fileWide : litExt),
    .modConst  (modConst),
    .fileAddr  (fileAddr),
    .fullSpace (isMoveOp),
    .effAddr   (srcEa),
    .ptrNext   (srcPtrNext),
    .ptrWrite  (srcPtrWr)
  );

  slg_ea_calc uDst (
    .mode      (dstMode),
    .ptrVal    (regs_q[dstPtrIdx]),
    .baseVal   (regs_q[baseIdx]),
    .litVal    (isFileOp ? fileWide : litExt),
    .modConst  (modConst),
    .fileAddr  (fileAddr),
    .fullSpace (isMoveOp),
    .effAddr   (dstEa),
    .ptrNext   (dstPtrNext),
    .ptrWrite  (dstPtrWr)
  );

  // ==========================================================================
  // Stack operation and trap check
  // ==========================================================================
  logic [slg_pkg::DW-1:0] stkAddr;
  logic [slg_pkg::DW-1:0] stkData;
  logic [slg_pkg::DW-1:0] spNext;
  logic                   stkWr;
  logic                   stkRd;
  logic                   isPush;
  logic                   overflow;
  logic                   underflow;
  logic                   srcIsSp;
  logic                   dstIsSp;
  logic                   eaOver;
  logic                   eaUnder;
  logic                   bootHit;

  always_comb begin
    stkAddr = sp;
    stkData = pushData;
    spNext  = sp;
    stkWr   = 1'b0;
    stkRd   = 1'b0;
    isPush  = 1'b0;
    case (stackOp)
      slg_pkg::SOP_PUSH: begin
        stkWr  = 1'b1;
        isPush = 1'b1;
        spNext = sp + slg_pkg::WORD_STEP;
      end
      slg_pkg::SOP_CALL: begin
        stkWr   = 1'b1;
        isPush  = 1'b1;
        stkData = {{(slg_pkg::DW-slg_pkg::PC_HI_W){1'b0}}, pcHigh[slg_pkg::PC_HI_W-1:0]};
        spNext  = sp + slg_pkg::WORD_STEP;
      end
      slg_pkg::SOP_EXC: begin
        stkWr   = 1'b1;
        isPush  = 1'b1;
        stkData = {statusLowByte, 1'b0, pcHigh[slg_pkg::PC_HI_W-1:0]};
        spNext  = sp + slg_pkg::WORD_STEP;
      end
      slg_pkg::SOP_POP: begin
        stkRd   = 1'b1;
        spNext  = sp - slg_pkg::WORD_STEP;
        stkAddr = sp - slg_pkg::WORD_STEP;
      end
      default: begin
        stkAddr = sp;
      end
    endcase
  end

  // A push at the limit writes the limit word itself and passes; the next one exceeds it.
  assign overflow  = isPush && (stkAddr > limit_q);
  assign underflow = (stackOp != slg_pkg::SOP_NONE) && (stkAddr < slg_pkg::STACK_FLOOR);
  assign srcIsSp   = opValid && (srcMode != slg_pkg::AM_FILE) && (srcMode != slg_pkg::AM_LITERAL) &&
                     (srcMode != slg_pkg::AM_DIRECT) && (srcPtrIdx == slg_pkg::SP_IDX);
  assign dstIsSp   = opValid && (dstMode != slg_pkg::AM_FILE) && (dstMode != slg_pkg::AM_LITERAL) &&
                     (dstMode != slg_pkg::AM_DIRECT) && (dstPtrIdx == slg_pkg::SP_IDX);
  // Stack-pointer addresses are checked against the limit and the floor.
  assign eaOver    = (srcIsSp && (srcEa > limit_q)) || (dstIsSp && (dstEa > limit_q));
  assign eaUnder   = (srcIsSp && (srcEa < slg_pkg::STACK_FLOOR)) || (dstIsSp && (dstEa < slg_pkg::STACK_FLOOR));
  assign bootHit   = opValid && bootRamEn && !execInBoot &&
                     (((srcEa >= bootRamLo) && (srcEa <= bootRamHi) && (srcMode != slg_pkg::AM_DIRECT)) ||
                      ((dstEa >= bootRamLo) && (dstEa <= bootRamHi) && (dstMode != slg_pkg::AM_DIRECT)));

  // Register file next state; stack move takes priority over an operand pointer update.
  always_comb begin
    for (int i = 0; i < slg_pkg::NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (regWrite) begin
      regs_d[regWrIdx] = regWrData; // Results may target working register zero.
    end
    if (opValid && srcPtrWr) begin
      regs_d[srcPtrIdx] = srcPtrNext;
    end
    if (opValid && dstPtrWr) begin
      regs_d[dstPtrIdx] = dstPtrNext;
    end
    if (stackOp != slg_pkg::SOP_NONE) begin
      regs_d[slg_pkg::SP_IDX] = spNext;
    end
    regs_d[slg_pkg::SP_IDX] = regs_d[slg_pkg::SP_IDX] & slg_pkg::ALIGN_MASK;
    limit_d = limitWrite ? (limitData & slg_pkg::ALIGN_MASK) : limit_q;
  end

  // Limit register has no reset term on purpose; it stays unknown until written.
  always_ff @(posedge clk) begin
    limit_q <= limit_d;
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < slg_pkg::NUM_REGS; i++) begin
      if (reset) begin
        regs_q[i] <= slg_pkg::STACK_FLOOR;
      end else begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      memAddr     <= '0;
      memWrData   <= '0;
      memWrite    <= 1'b0;
      memRead     <= 1'b0;
      srcAddr     <= '0;
      dstAddr     <= '0;
      baseOperand <= '0;
      litOut      <= '0;
      stackPtr    <= slg_pkg::STACK_FLOOR;
      stackTrap   <= 1'b0;
      secureFault <= 1'b0;
    end else begin
      memAddr     <= stkAddr;
      memWrData   <= stkData;
      memWrite    <= stkWr && !overflow && !underflow;
      memRead     <= stkRd && !underflow;
      srcAddr     <= srcEa;
      dstAddr     <= dstEa;
      baseOperand <= regs_q[baseIdx];
      litOut      <= litExt;
      stackPtr    <= regs_d[slg_pkg::SP_IDX];
      stackTrap   <= overflow || underflow || eaOver || eaUnder;
      secureFault <= bootHit;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_push_post_inc: assert property (@(posedge clk) disable iff (reset)
    (stackOp == slg_pkg::SOP_PUSH) |=> (stackPtr == (($past(sp) + slg_pkg::WORD_STEP) & slg_pkg::ALIGN_MASK)))
    else $error("push did not advance stack pointer by one word");

  chk_pop_pre_dec: assert property (@(posedge clk) disable iff (reset)
    (stackOp == slg_pkg::SOP_POP) |=> (memAddr == $past(sp) - slg_pkg::WORD_STEP))
    else $error("pop did not read the word below the pointer");

  chk_call_msb_clear: assert property (@(posedge clk) disable iff (reset)
    (stackOp == slg_pkg::SOP_CALL) |=> !memWrData[slg_pkg::PC_HI_W])
    else $error("call push left the top bit set");

  chk_exc_status: assert property (@(posedge clk) disable iff (reset)
    (stackOp == slg_pkg::SOP_EXC) |=> (memWrData[slg_pkg::DW-1 -: slg_pkg::STAT_LO_W] == $past(statusLowByte)))
    else $error("exception push lost the status byte");

  chk_limit_align: assert property (@(posedge clk) disable iff (reset)
    limitWrite |=> !limit_q[0])
    else $error("limit bit zero not forced low");

  chk_limit_equal_ok: assert property (@(posedge clk) disable iff (reset)
    ((stackOp == slg_pkg::SOP_PUSH) && (sp == limit_q) && (sp >= slg_pkg::STACK_FLOOR) && !eaOver && !eaUnder)
      |=> !stackTrap)
    else $error("push at the limit trapped");

  chk_over_trap: assert property (@(posedge clk) disable iff (reset)
    (isPush && (sp > limit_q)) |=> stackTrap)
    else $error("push beyond the limit did not trap");

  chk_under_trap: assert property (@(posedge clk) disable iff (reset)
    ((stackOp == slg_pkg::SOP_PUSH) && (sp < slg_pkg::STACK_FLOOR)) |=> (stackTrap && !memWrite))
    else $error("underflow did not trap");

  chk_boot_guard: assert property (@(posedge clk) disable iff (reset)
    (opValid && bootRamEn && execInBoot) |=> !secureFault)
    else $error("boot code refused boot secure RAM");

  chk_boot_refuse: assert property (@(posedge clk) disable iff (reset)
    (opValid && bootRamEn && !execInBoot && (srcMode == slg_pkg::AM_INDIRECT) &&
     (regs_q[srcPtrIdx] >= bootRamLo) && (regs_q[srcPtrIdx] <= bootRamHi)) |=> secureFault)
    else $error("outside code reached boot secure RAM");

endmodule : slg_stack_ea

//--- tb/slg_mem_model.sv
// Data memory model that sits on the far side of the stack and address block.
// Assumes one registered write request per cycle and reads answered by the bench.
`timescale 1ns/10ps
module slg_mem_model (
  input  wire logic                   clk,       // Core clock.
  input  wire logic [slg_pkg::DW-1:0] memAddr,   // Byte address from the block.
  input  wire logic [slg_pkg::DW-1:0] memWrData, // Write data.
  input  wire logic                   memWrite,  // Write strobe.
  input  wire logic [slg_pkg::DW-1:0] peekAddr,  // Bench look-up address.
  output logic      [slg_pkg::DW-1:0] peekData   // Word held there.
);
  // ==========================================================================
  // Word store
  // ==========================================================================
  // Words are stored by word index, so an odd address would alias its pair.
  logic [slg_pkg::DW-1:0] store [0:32767];

  always @(posedge clk) begin
    if (memWrite === 1'b1) begin
      store[memAddr[15:1]] <= memWrData;
    end
  end

  assign peekData = store[peekAddr[15:1]];
endmodule : slg_mem_model

//--- tb/tb_slg_stack_ea.sv
// Self-checking bench for the stack pointer, limit check and address former.
// Assumes one-cycle registered answers as described for the block's ports.
`timescale 1ns/10ps
module tb_slg_stack_ea;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic clk = 1'b0, reset = 1'b1, limitWrite = 1'b0, regWrite = 1'b0, opValid = 1'b0;
  logic isFileOp = 1'b0, isMoveOp = 1'b0, bootRamEn = 1'b0, execInBoot = 1'b0;
  slg_pkg::slg_stack_op_e stackOp = slg_pkg::SOP_NONE;
  slg_pkg::slg_mode_e     srcMode = slg_pkg::AM_INDIRECT, dstMode = slg_pkg::AM_INDIRECT;
  slg_pkg::slg_lit_e      litKind = slg_pkg::LIT_5;
  logic [15:0] pushData = 16'h0000, limitData = 16'h0000, regWrData = 16'h0000, wideAddr = 16'h0000;
  logic [15:0] litRaw = 16'h0000, modConst = 16'h0000, bootRamLo = 16'h1000, bootRamHi = 16'h10FF;
  logic [15:0] peekAddr = 16'h0800;
  logic [7:0]  pcHigh = 8'h00, statusLowByte = 8'h00;
  logic [3:0]  regWrIdx = 4'h0, srcPtrIdx = 4'h1, dstPtrIdx = 4'h1, baseIdx = 4'h2;
  logic [12:0] fileAddr = 13'h0000;
  logic [15:0] memAddr, memWrData, srcAddr, dstAddr, baseOperand, litOut, stackPtr, peekData;
  logic        memWrite, memRead, stackTrap, secureFault;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0;

  slg_stack_ea DUT (.clk(clk), .reset(reset), .stackOp(stackOp), .pushData(pushData), .pcHigh(pcHigh),
    .statusLowByte(statusLowByte), .limitWrite(limitWrite), .limitData(limitData), .regWrite(regWrite),
    .regWrIdx(regWrIdx), .regWrData(regWrData), .opValid(opValid), .isFileOp(isFileOp), .isMoveOp(isMoveOp),
    .srcMode(srcMode), .dstMode(dstMode), .srcPtrIdx(srcPtrIdx), .dstPtrIdx(dstPtrIdx), .baseIdx(baseIdx),
    .fileAddr(fileAddr), .wideAddr(wideAddr), .litKind(litKind), .litRaw(litRaw), .modConst(modConst),
    .bootRamEn(bootRamEn), .bootRamLo(bootRamLo), .bootRamHi(bootRamHi), .execInBoot(execInBoot),
    .memAddr(memAddr), .memWrData(memWrData), .memWrite(memWrite), .memRead(memRead), .srcAddr(srcAddr),
    .dstAddr(dstAddr), .baseOperand(baseOperand), .litOut(litOut), .stackPtr(stackPtr),
    .stackTrap(stackTrap), .secureFault(secureFault));

  slg_mem_model memModel (.clk(clk), .memAddr(memAddr), .memWrData(memWrData), .memWrite(memWrite),
    .peekAddr(peekAddr), .peekData(peekData));

  always #5 clk = ~clk;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // A cycle limit stops a hung run; the whole sequence needs about 150 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic do_reset();
    reset = 1'b1;
    repeat (20) tick();
    reset = 1'b0;
  endtask : do_reset

  // The decoder leaves one idle cycle after a limit write before any stack access.
  task automatic set_limit(input logic [15:0] val);
    limitWrite = 1'b1;
    limitData = val;
    tick();
    limitWrite = 1'b0;
    tick();
  endtask : set_limit

  task automatic set_reg(input logic [3:0] idx, input logic [15:0] val);
    regWrite = 1'b1;
    regWrIdx = idx;
    regWrData = val;
    tick();
    regWrite = 1'b0;
    tick();
  endtask : set_reg

  // The operation is left applied so that callers can issue them back to back.
  task automatic do_stack(input slg_pkg::slg_stack_op_e op, input logic [15:0] expAddr, input logic expWr,
                          input logic expRd, input logic expTrap, input logic [15:0] expSp);
    stackOp = op;
    tick();
    chk1("memWrite", expWr, memWrite);
    chk1("memRead", expRd, memRead);
    chk1("stackTrap", expTrap, stackTrap);
    if (!expTrap) chk16("memAddr", expAddr, memAddr);
    if (!expTrap) chk16("stackPtr", expSp, stackPtr);
  endtask : do_stack

  task automatic ea(input slg_pkg::slg_mode_e mode, input logic [15:0] exp);
    srcMode = mode;
    opValid = 1'b1;
    tick();
    chk16("srcAddr", exp, srcAddr);
  endtask : ea

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_push_pop();
    chk16("stackPtr", 16'h0800, stackPtr);
    set_limit(16'h0FFF);
    pushData = 16'h1234;
    do_stack(slg_pkg::SOP_PUSH, 16'h0800, 1'b1, 1'b0, 1'b0, 16'h0802);
    pushData = 16'hBEEF;
    do_stack(slg_pkg::SOP_PUSH, 16'h0802, 1'b1, 1'b0, 1'b0, 16'h0804);
    chk16("memWrData", 16'hBEEF, memWrData);
    pcHigh = 8'hFF;
    do_stack(slg_pkg::SOP_CALL, 16'h0804, 1'b1, 1'b0, 1'b0, 16'h0806);
    chk16("memWrData", 16'h007F, memWrData);
    statusLowByte = 8'hA5;
    pcHigh = 8'hC3;
    do_stack(slg_pkg::SOP_EXC, 16'h0806, 1'b1, 1'b0, 1'b0, 16'h0808);
    chk16("memWrData", 16'hA543, memWrData);
    do_stack(slg_pkg::SOP_POP, 16'h0806, 1'b0, 1'b1, 1'b0, 16'h0806);
    do_stack(slg_pkg::SOP_POP, 16'h0804, 1'b0, 1'b1, 1'b0, 16'h0804);
    stackOp = slg_pkg::SOP_NONE;
    peekAddr = 16'h0802;
    tick();
    chk16("stored word", 16'hBEEF, peekData);
  endtask : s_push_pop

  task automatic s_limit();
    do_reset();
    set_limit(16'h0805);
    do_stack(slg_pkg::SOP_PUSH, 16'h0800, 1'b1, 1'b0, 1'b0, 16'h0802);
    do_stack(slg_pkg::SOP_PUSH, 16'h0802, 1'b1, 1'b0, 1'b0, 16'h0804);
    do_stack(slg_pkg::SOP_PUSH, 16'h0804, 1'b1, 1'b0, 1'b0, 16'h0806);
    do_stack(slg_pkg::SOP_PUSH, 16'h0806, 1'b0, 1'b0, 1'b1, 16'h0808);
    stackOp = slg_pkg::SOP_NONE;
    tick();
    chk1("stackTrap", 1'b0, stackTrap);
    do_reset();
    set_limit(16'h0FFE);
    do_stack(slg_pkg::SOP_POP, 16'h07FE, 1'b0, 1'b0, 1'b1, 16'h07FE);
    stackOp = slg_pkg::SOP_NONE;
    do_reset();
    set_limit(16'h0FFE);
    set_reg(4'hF, 16'h0600);
    srcPtrIdx = 4'hF;
    ea(slg_pkg::AM_INDIRECT, 16'h0600);
    chk1("stackTrap", 1'b1, stackTrap);
    opValid = 1'b0;
    srcPtrIdx = 4'h1;
    do_stack(slg_pkg::SOP_PUSH, 16'h0600, 1'b0, 1'b0, 1'b1, 16'h0602);
    stackOp = slg_pkg::SOP_NONE;
  endtask : s_limit

  task automatic s_modes();
    do_reset();
    set_reg(4'h1, 16'h1000);
    set_reg(4'h2, 16'h0040);
    ea(slg_pkg::AM_INDIRECT, 16'h1000);
    modConst = 16'h0002;
    ea(slg_pkg::AM_POST_MOD, 16'h1000);
    ea(slg_pkg::AM_INDIRECT, 16'h1002);
    modConst = 16'hFFFE;
    ea(slg_pkg::AM_PRE_MOD, 16'h1000);
    ea(slg_pkg::AM_INDEXED, 16'h1040);
    chk16("baseOperand", 16'h0040, baseOperand);
    litRaw = 16'hFFE3;
    ea(slg_pkg::AM_LIT_OFFSET, 16'h1003);
    isFileOp = 1'b1;
    fileAddr = 13'h1FFF;
    wideAddr = 16'hABCD;
    ea(slg_pkg::AM_FILE, 16'h1FFF);
    isMoveOp = 1'b1;
    ea(slg_pkg::AM_FILE, 16'hABCD);
    isFileOp = 1'b0;
    dstMode = slg_pkg::AM_INDEXED;
    ea(slg_pkg::AM_INDIRECT, 16'h1000);
    chk16("dstAddr", 16'h1040, dstAddr);
    isMoveOp = 1'b0;
    litRaw = 16'hFFFF;
    for (int k = 0; k < 4; k++) begin
      litKind = slg_pkg::slg_lit_e'(k);
      ea(slg_pkg::AM_INDIRECT, 16'h1000);
      chk16("litOut", (k == 0) ? 16'h001F : (k == 1) ? 16'h03FF : (k == 2) ? 16'hFFFF : 16'h3FFF,
            litOut);
    end
  endtask : s_modes

  task automatic s_boot();
    bootRamEn = 1'b1;
    ea(slg_pkg::AM_INDIRECT, 16'h1000);
    chk1("secureFault", 1'b1, secureFault);
    execInBoot = 1'b1;
    ea(slg_pkg::AM_INDIRECT, 16'h1000);
    chk1("secureFault", 1'b0, secureFault);
    execInBoot = 1'b0;
    bootRamEn = 1'b0;
    ea(slg_pkg::AM_INDIRECT, 16'h1000);
    chk1("secureFault", 1'b0, secureFault);
    opValid = 1'b0;
  endtask : s_boot

  initial begin
    do_reset();
    s_push_pop();
    s_limit();
    s_modes();
    s_boot();
    tick();
    complete_run();
  end
endmodule : tb_slg_stack_ea
